// ---- cpm_params.svh ----
// constants for the clock, power and flash pulse control block
`ifndef CPM_PARAMS_SVH
`define CPM_PARAMS_SVH

// register addresses
`define CPM_ADDR_CPU_PWR      16'h0087
`define CPM_ADDR_MCLK_CTL     16'h008F
`define CPM_ADDR_FLASH_PULSE  16'hFFF2

// reset values
`define CPM_RST_CPU_PWR       8'h00
`define CPM_RST_MCLK_CTL      8'h0A
`define CPM_RST_FLASH_PULSE   8'h10

// writable bit masks, the rest reads zero except mclk ctl bit 3, which reset sets until the first write
`define CPM_MASK_CPU_PWR      8'h8F
`define CPM_MASK_MCLK_CTL     8'hE7
`define CPM_MASK_FLASH_PULSE  8'h30

// field positions
`define CPM_BIT_BAUD_DOUBLE   7
`define CPM_BIT_CPU_STOP      1
`define CPM_BIT_CPU_IDLE      0
`define CPM_BIT_OSC_DIS       7
`define CPM_BIT_KEYPAD_DIS    6
`define CPM_BIT_CARD_DIS      5
`define CPM_MULT_MSB          2
`define CPM_MULT_LSB          0
`define CPM_BIT_BYPASS        5
`define CPM_BIT_LONG_PULSE    4

// pll ratio = multiplier * 2 + 4
`define CPM_MULT_SCALE        5'h02
`define CPM_MULT_OFFSET       5'h04

// timing
`define CPM_CLK_PERIOD_NS     10
`define CPM_SHORT_PULSE_NS    40
`define CPM_LONG_PULSE_NS     66
`define CPM_SHORT_PULSE_CYC   (`CPM_SHORT_PULSE_NS / `CPM_CLK_PERIOD_NS)
`define CPM_LONG_PULSE_CYC    (`CPM_LONG_PULSE_NS / `CPM_CLK_PERIOD_NS)
`define CPM_PD_DELAY_CYC      6'h20

`endif

// ---- cpm_pkg.sv ----
// types for the clock, power and flash pulse control block
package cpm_pkg;
    typedef logic [7:0]  cpm_byte_t;
    typedef logic [15:0] cpm_addr_t;
    typedef logic [4:0]  cpm_ratio_t;
    typedef enum logic [1:0] {
        CPM_FRP_IDLE = 2'b00,
        CPM_FRP_HIGH = 2'b01,
        CPM_FRP_HOLD = 2'b10
    } cpm_frp_state_t;
endpackage

// ---- cpm_clock_power_ctrl.sv ----
// clock, power and flash read pulse control registers with their logic
`timescale 1ns/1ps
`include "cpm_params.svh"

module cpm_clock_power_ctrl (
    input  wire logic                mclk,
    input  wire logic                sys_rst,
    input  wire cpm_pkg::cpm_addr_t  sfr_addr,
    input  wire cpm_pkg::cpm_byte_t  sfr_wdata,
    input  wire logic                sfr_wr,
    input  wire logic                sfr_rd,
    output cpm_pkg::cpm_byte_t       sfr_rdata,
    input  wire logic                power_down_request,
    input  wire logic                cpu_wake,
    input  wire logic                flash_rd_in,
    output logic                     flash_rd_out,
    output logic                     osc_pll_enable,
    output cpm_pkg::cpm_ratio_t      pll_ratio,
    output logic                     keypad_clk_enable,
    output logic                     card_clk_enable,
    input  wire logic                card_detect_pin,
    output logic                     card_detect_event,
    output logic                     baud_double,
    output logic                     cpu_stop_req,
    output logic                     cpu_idle_req
);
    import cpm_pkg::*;

    // ----------------------------------------------------------------
    // register file
    // ----------------------------------------------------------------
    cpm_byte_t cpu_power_control_r,    cpu_power_control_nxt;
    cpm_byte_t master_clock_control_r, master_clock_control_nxt;
    cpm_byte_t flash_pulse_control_r,  flash_pulse_control_nxt;
    cpm_byte_t rdata_r,                rdata_nxt;

    // writes masked so unused bits are written zero; a software write beats a wake
    always_comb begin
        cpu_power_control_nxt    = cpu_power_control_r;
        master_clock_control_nxt = master_clock_control_r;
        flash_pulse_control_nxt  = flash_pulse_control_r;
        rdata_nxt                = rdata_r;
        if (cpu_wake) begin
            cpu_power_control_nxt[`CPM_BIT_CPU_STOP] = 1'b0;
            cpu_power_control_nxt[`CPM_BIT_CPU_IDLE] = 1'b0;
        end
        if (sfr_wr) begin
            unique case (sfr_addr)
                `CPM_ADDR_CPU_PWR:     cpu_power_control_nxt    = sfr_wdata & `CPM_MASK_CPU_PWR;
                `CPM_ADDR_MCLK_CTL:    master_clock_control_nxt = sfr_wdata & `CPM_MASK_MCLK_CTL;
                `CPM_ADDR_FLASH_PULSE: flash_pulse_control_nxt  = sfr_wdata & `CPM_MASK_FLASH_PULSE;
                default: begin
                end
            endcase
        end
        if (sfr_rd) begin
            unique case (sfr_addr)
                `CPM_ADDR_CPU_PWR:     rdata_nxt = cpu_power_control_r;
                `CPM_ADDR_MCLK_CTL:    rdata_nxt = master_clock_control_r;
                `CPM_ADDR_FLASH_PULSE: rdata_nxt = flash_pulse_control_r;
                default:               rdata_nxt = 8'h00; // unmapped reads zero
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            cpu_power_control_r    <= `CPM_RST_CPU_PWR;
            master_clock_control_r <= `CPM_RST_MCLK_CTL;
            flash_pulse_control_r  <= `CPM_RST_FLASH_PULSE;
            rdata_r                <= 8'h00;
        end else begin
            cpu_power_control_r    <= cpu_power_control_nxt;
            master_clock_control_r <= master_clock_control_nxt;
            flash_pulse_control_r  <= flash_pulse_control_nxt;
            rdata_r                <= rdata_nxt;
        end
    end

    assign sfr_rdata = rdata_r;

    // ----------------------------------------------------------------
    // power-down delay
    // ----------------------------------------------------------------
    logic [5:0] pd_count_r, pd_count_nxt;
    logic       pd_off_r,   pd_off_nxt;

    // the delay leaves the cpu time to request stop before clocks die
    always_comb begin
        pd_count_nxt = pd_count_r;
        pd_off_nxt   = pd_off_r;
        if (!power_down_request) begin
            pd_count_nxt = 6'h00;
            pd_off_nxt   = 1'b0;
        end else if (!pd_off_r) begin
            pd_count_nxt = pd_count_r + 6'h01;
            if (pd_count_nxt == `CPM_PD_DELAY_CYC) begin
                pd_off_nxt = 1'b1;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            pd_count_r <= 6'h00;
            pd_off_r   <= 1'b0;
        end else begin
            pd_count_r <= pd_count_nxt;
            pd_off_r   <= pd_off_nxt;
        end
    end

    // ----------------------------------------------------------------
    // clock gating and cpu controls
    // ----------------------------------------------------------------
    // power-down overrides the gates without touching the stored bits
    assign osc_pll_enable    = ~master_clock_control_r[`CPM_BIT_OSC_DIS] & ~pd_off_r;
    assign keypad_clk_enable = ~master_clock_control_r[`CPM_BIT_KEYPAD_DIS] & ~pd_off_r;
    assign card_clk_enable   = ~master_clock_control_r[`CPM_BIT_CARD_DIS] & ~pd_off_r;
    assign pll_ratio = 5'(master_clock_control_r[`CPM_MULT_MSB:`CPM_MULT_LSB]) * `CPM_MULT_SCALE
                       + `CPM_MULT_OFFSET;
    assign baud_double  = cpu_power_control_r[`CPM_BIT_BAUD_DOUBLE];
    assign cpu_stop_req = cpu_power_control_r[`CPM_BIT_CPU_STOP];
    assign cpu_idle_req = cpu_power_control_r[`CPM_BIT_CPU_IDLE];

    // card detect synchroniser runs on mclk, independent of the card gate
    logic det_meta_r, det_sync_r, det_prev_r;
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            det_meta_r <= 1'b0;
            det_sync_r <= 1'b0;
            det_prev_r <= 1'b0;
        end else begin
            det_meta_r <= card_detect_pin;
            det_sync_r <= det_meta_r;
            det_prev_r <= det_sync_r;
        end
    end
    // one pulse per settled change; the pin is seen two edges late
    // both insertion and removal pulse, the interrupt side picks the sense
    assign card_detect_event = det_sync_r ^ det_prev_r;

    // ----------------------------------------------------------------
    // flash read pulse shortener
    // ----------------------------------------------------------------
    cpm_frp_state_t frp_state_r, frp_state_nxt;
    logic [2:0]     frp_count_r, frp_count_nxt;
    logic           frp_out_r,   frp_out_nxt;
    logic [2:0]     frp_width;

    // widths floored to whole mclk cycles, so the strobe errs on the short side
    // a slower mclk would need the counts rescaled, hence the period constant
    assign frp_width = flash_pulse_control_r[`CPM_BIT_LONG_PULSE] ?
                       3'(`CPM_LONG_PULSE_CYC) : 3'(`CPM_SHORT_PULSE_CYC);

    // one-shot: width capped in time and cut short if the raw strobe drops, strobe then held low until it drops
    always_comb begin
        frp_state_nxt = frp_state_r;
        frp_count_nxt = frp_count_r;
        frp_out_nxt   = 1'b0;
        unique case (frp_state_r)
            CPM_FRP_IDLE: begin
                if (flash_rd_in) begin
                    frp_state_nxt = CPM_FRP_HIGH;
                    frp_count_nxt = frp_width - 3'h1;
                    frp_out_nxt   = 1'b1;
                end
            end
            CPM_FRP_HIGH: begin
                if (!flash_rd_in) begin
                    frp_state_nxt = CPM_FRP_IDLE;
                end else if (frp_count_r == 3'h0) begin
                    frp_state_nxt = CPM_FRP_HOLD;
                end else begin
                    frp_count_nxt = frp_count_r - 3'h1;
                    frp_out_nxt   = 1'b1;
                end
            end
            CPM_FRP_HOLD: begin
                if (!flash_rd_in) begin
                    frp_state_nxt = CPM_FRP_IDLE;
                end
            end
            default: frp_state_nxt = CPM_FRP_IDLE;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            frp_state_r <= CPM_FRP_IDLE;
            frp_count_r <= 3'h0;
            frp_out_r   <= 1'b0;
        end else begin
            frp_state_r <= frp_state_nxt;
            frp_count_r <= frp_count_nxt;
            frp_out_r   <= frp_out_nxt;
        end
    end

    // bypass passes the raw strobe for fast clocks
    assign flash_rd_out = flash_pulse_control_r[`CPM_BIT_BYPASS] ? flash_rd_in : frp_out_r;

endmodule

// ---- cpm_ctrl_properties.sv ----
// concurrent checks for the clock, power and flash pulse control block
`timescale 1ns/1ps
module cpm_ctrl_properties (
    input wire logic                mclk,
    input wire logic                sys_rst,
    input wire cpm_pkg::cpm_addr_t  sfr_addr,
    input wire cpm_pkg::cpm_byte_t  sfr_wdata,
    input wire logic                sfr_wr,
    input wire logic                sfr_rd,
    input wire cpm_pkg::cpm_byte_t  sfr_rdata,
    input wire logic                power_down_request,
    input wire logic                cpu_wake,
    input wire logic                flash_rd_in,
    input wire logic                flash_rd_out,
    input wire logic                osc_pll_enable,
    input wire cpm_pkg::cpm_ratio_t pll_ratio,
    input wire logic                keypad_clk_enable,
    input wire logic                card_clk_enable,
    input wire logic                card_detect_pin,
    input wire logic                card_detect_event,
    input wire logic                baud_double,
    input wire logic                cpu_stop_req,
    input wire logic                cpu_idle_req
);
    import cpm_pkg::*;
    logic       byp_r, long_r, baud_r;
    logic [7:0] clk_r;
    logic [5:0] pd_cnt_r;
    // shadow of written bits; the pd counter saturates so long requests never wrap
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            {byp_r, long_r, baud_r, clk_r, pd_cnt_r} <= {3'b010, 8'h0A, 6'h00};
        end else begin
            if (sfr_wr && sfr_addr == 16'hFFF2) {byp_r, long_r} <= sfr_wdata[5:4];
            if (sfr_wr && sfr_addr == 16'h008F) clk_r <= sfr_wdata & 8'hE7;
            if (sfr_wr && sfr_addr == 16'h0087) baud_r <= sfr_wdata[7];
            pd_cnt_r <= !power_down_request ? 6'h00 : (pd_cnt_r == 6'h3F ? pd_cnt_r : pd_cnt_r + 6'h01);
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    bypass_pass_a: assert property (byp_r |-> flash_rd_out == flash_rd_in)
        else $error("flash strobe altered in bypass");
    strobe_cause_a: assert property (!byp_r && $rose(flash_rd_out) |-> $past(flash_rd_in))
        else $error("shortened strobe without raw strobe");
    ratio_calc_a: assert property (pll_ratio == {1'b0, clk_r[2:0], 1'b0} + 5'h04)
        else $error("pll ratio wrong");
    osc_gate_a: assert property (clk_r[7] |-> !osc_pll_enable)
        else $error("oscillator runs while disabled");
    keypad_gate_a: assert property (clk_r[6] |-> !keypad_clk_enable)
        else $error("keypad clock runs while disabled");
    card_gate_a: assert property (clk_r[5] |-> !card_clk_enable)
        else $error("card clock runs while disabled");
    pd_off_a: assert property (pd_cnt_r >= 6'd32 |-> !(osc_pll_enable | keypad_clk_enable | card_clk_enable))
        else $error("analog still on in power-down");
    pd_wait_a: assert property (pd_cnt_r <= 6'd31 && !clk_r[7] |-> osc_pll_enable)
        else $error("analog off too early");
    baud_bit_a: assert property (baud_double == baud_r)
        else $error("baud double mismatch");
    stop_cause_a: assert property ($rose(cpu_stop_req) |-> $past(sfr_wr && sfr_addr == 16'h0087 && sfr_wdata[1]))
        else $error("stop without write");
    unmapped_zero_a: assert property (sfr_rd && !(sfr_addr inside {16'h0087, 16'h008F, 16'hFFF2}) |=> sfr_rdata == 8'h00)
        else $error("unmapped read not zero");
    detect_live_a: assert property ($changed(card_detect_pin) |-> ##[1:4] card_detect_event)
        else $error("card detect event missing");
    cover property (pd_cnt_r == 6'd33);
    cover property ($rose(flash_rd_out) && !byp_r);
    cover property (card_detect_event && clk_r[5]);
endmodule
bind cpm_clock_power_ctrl cpm_ctrl_properties u_prop (.mclk, .sys_rst, .sfr_addr, .sfr_wdata, .sfr_wr, .sfr_rd,
    .sfr_rdata, .power_down_request, .cpu_wake, .flash_rd_in, .flash_rd_out, .osc_pll_enable, .pll_ratio,
    .keypad_clk_enable, .card_clk_enable, .card_detect_pin, .card_detect_event, .baud_double, .cpu_stop_req,
    .cpu_idle_req);

// ---- tb.sv ----
// self-checking testbench for the clock, power and flash pulse control block
`timescale 1ns/1ps
module tb;
    import cpm_pkg::*;
    logic       mclk = 1'b0, sys_rst = 1'b1, sfr_wr = 1'b0, sfr_rd = 1'b0, power_down_request = 1'b0;
    logic       cpu_wake = 1'b0, flash_rd_in = 1'b0, card_detect_pin = 1'b0;
    cpm_addr_t  sfr_addr = 16'h0000;
    cpm_byte_t  sfr_wdata = 8'h00, sfr_rdata;
    cpm_ratio_t pll_ratio;
    logic       flash_rd_out, osc_pll_enable, keypad_clk_enable, card_clk_enable, card_detect_event;
    logic       baud_double, cpu_stop_req, cpu_idle_req;
    int         n_mismatch = 0, checked = 0, cnt;
    always #5 mclk = ~mclk;
    cpm_clock_power_ctrl u_dut (.mclk, .sys_rst, .sfr_addr, .sfr_wdata, .sfr_wr, .sfr_rd, .sfr_rdata,
        .power_down_request, .cpu_wake, .flash_rd_in, .flash_rd_out, .osc_pll_enable, .pll_ratio,
        .keypad_clk_enable, .card_clk_enable, .card_detect_pin, .card_detect_event, .baud_double,
        .cpu_stop_req, .cpu_idle_req);
    // ----------------------------------------
    // access and compare tasks
    // ----------------------------------------
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // inputs move on the falling edge so the rising edge sees them settled
    task automatic wr(input cpm_addr_t a, input cpm_byte_t d);
        @(negedge mclk);
        {sfr_addr, sfr_wdata, sfr_wr} = {a, d, 1'b1};
        @(negedge mclk);
        sfr_wr = 1'b0;
    endtask
    task automatic rc(input cpm_addr_t a, input cpm_byte_t e);
        @(negedge mclk);
        {sfr_addr, sfr_rd} = {a, 1'b1};
        @(negedge mclk);
        sfr_rd = 1'b0;
        chk("rdata", sfr_rdata, e);
    endtask
    // holds the raw strobe ten cycles and counts cycles with the output high
    task automatic strobe(output int w);
        w = 0;
        @(negedge mclk);
        flash_rd_in = 1'b1;
        repeat (10) begin
            @(negedge mclk);
            if (flash_rd_out === 1'b1) w++;
        end
        flash_rd_in = 1'b0;
        repeat (2) @(negedge mclk);
    endtask
    task automatic results();
        $display("checked %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // ----------------------------------------
    // test sequence
    // ----------------------------------------
    initial begin
        repeat (12) @(negedge mclk);
        sys_rst = 1'b0;
        rc(16'h0087, 8'h00);
        rc(16'h008F, 8'h0A);
        rc(16'hFFF2, 8'h10);
        chk("pll_ratio", {3'h0, pll_ratio}, 8'h08);
        wr(16'h0087, 8'hFC);
        rc(16'h0087, 8'h8C);
        chk("baud_double", {7'h0, baud_double}, 8'h01);
        wr(16'hFFF2, 8'hCF);
        rc(16'hFFF2, 8'h00);
        wr(16'h0088, 8'hFF);
        rc(16'h0088, 8'h00);
        // every multiplier code, with unused bits set to prove they are dropped
        for (int m = 0; m < 8; m++) begin
            wr(16'h008F, 8'(m) | 8'h18);
            chk("pll_ratio", {3'h0, pll_ratio}, 8'(2 * m + 4));
        end
        rc(16'h008F, 8'h07);
        for (int b = 5; b < 8; b++) begin
            wr(16'h008F, 8'h02 | (8'h01 << b));
            chk("enables", {5'h0, osc_pll_enable, keypad_clk_enable, card_clk_enable},
                8'h07 & ~(8'h01 << (b - 5)));
        end
        // insertion must still be seen with the card clock gated
        wr(16'h008F, 8'h22);
        card_detect_pin = 1'b1;
        cnt = 0;
        repeat (6) @(negedge mclk) if (card_detect_event === 1'b1) cnt++;
        chk("detect events", 8'(cnt), 8'h01);
        wr(16'h0087, 8'h02);
        chk("stop idle", {6'h0, cpu_stop_req, cpu_idle_req}, 8'h02);
        cpu_wake = 1'b1;
        @(negedge mclk);
        cpu_wake = 1'b0;
        chk("stop idle", {6'h0, cpu_stop_req, cpu_idle_req}, 8'h00);
        wr(16'h0087, 8'h01);
        chk("stop idle", {6'h0, cpu_stop_req, cpu_idle_req}, 8'h01);
        wr(16'h0087, 8'h0C);
        rc(16'h0087, 8'h0C);
        chk("flags quiet", {5'h0, baud_double, cpu_stop_req, cpu_idle_req}, 8'h00);
        // power-down: analog parts stop at the 32nd edge that sees the request
        wr(16'h008F, 8'h02);
        power_down_request = 1'b1;
        cnt = 0;
        while (osc_pll_enable === 1'b1 && cnt < 40) begin
            @(negedge mclk);
            cnt++;
        end
        chk("pd delay", 8'(cnt), 8'd32);
        chk("pd enables", {6'h0, keypad_clk_enable, card_clk_enable}, 8'h00);
        rc(16'h008F, 8'h02);
        power_down_request = 1'b0;
        @(negedge mclk);
        chk("enables", {5'h0, osc_pll_enable, keypad_clk_enable, card_clk_enable}, 8'h07);
        for (int l = 0; l < 2; l++) begin
            wr(16'hFFF2, (l == 1) ? 8'h10 : 8'h00);
            strobe(cnt);
            chk("pulse width", 8'(cnt), (l == 1) ? 8'd6 : 8'd4);
        end
        wr(16'hFFF2, 8'h20);
        flash_rd_in = 1'b1;
        #1 chk("bypass", {7'h0, flash_rd_out}, 8'h01);
        repeat (10) @(negedge mclk);
        chk("bypass", {7'h0, flash_rd_out}, 8'h01);
        flash_rd_in = 1'b0;
        #1 chk("bypass", {7'h0, flash_rd_out}, 8'h00);
        results();
    end
    // the sequence needs about 150 cycles; five thousand means a hang
    initial begin
        #50000;
        n_mismatch++;
        results();
    end
endmodule
